// ---- verilog/amdd_pkg.sv ----
`default_nettype none
package amdd_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_HZ = 20000000;  // System clock rate
    localparam int TICK_US = 1000;     // Timer tick period, microseconds
    // Clock cycles per timer tick, derived from rate and tick period
    localparam int TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
    localparam logic [12:0] SHOW_MS = 13'd3000;  // Channel error display
    localparam logic [12:0] ADDR_MS = 13'd5000;  // Address switch display
    localparam logic [12:0] HOLD_MS = 13'd5000;  // Button hold for ack
    localparam logic [12:0] FLASH_MS = 13'd250;  // Half period of flashing

    // ****************************************
    // Input word window
    // ****************************************
    localparam int NCH = 8;               // Analog input channels
    localparam int WINDOW_SW = 7;         // Switch eight selects window
    localparam logic [3:0] WIN_LO = 4'h0; // Base offset, switch off
    localparam logic [3:0] WIN_HI = 4'h8; // Base offset, switch on

    // ****************************************
    // Error report fields
    // ****************************************
    localparam logic [3:0] ERR_CLASS_FOUR = 4'h4;  // Class of both reports
    localparam logic [7:0] ERRNO_OPEN = 8'h09;     // Open circuit
    localparam logic [7:0] ERRNO_OVF = 8'h0a;      // Overflow, ten decimal
    localparam logic [7:0] DEV_TYPE = 8'h3c;       // Value is arbitrary

    // ****************************************
    // Per-channel error display bits
    // ****************************************
    localparam int DIAG_UNIT = 0;
    localparam int DIAG_BUS = 1;
    localparam int DIAG_OPEN = 3;
    localparam int DIAG_OVF = 4;

    // ****************************************
    // Measuring range codes and bar scaling
    // ****************************************
    localparam logic [1:0] RNG_BIPOLAR = 2'h0;  // Voltage, +/- full span
    localparam logic [1:0] RNG_LIVEZ = 2'h1;    // 4 to 20 mA
    localparam logic [1:0] RNG_RTD = 2'h2;      // Resistance thermometer
    localparam logic [1:0] RNG_TC = 2'h3;       // Thermocouple
    // Offset added to the word, multiplier and right shift per range
    localparam logic signed [17:0] BAR_OFF_BIP = 18'sh08000;
    localparam logic signed [17:0] BAR_OFF_LZ = -18'sh0199a;
    localparam logic signed [17:0] BAR_OFF_RTD = 18'sh00400;
    localparam logic signed [17:0] BAR_OFF_TC = 18'sh00000;
    localparam logic [4:0] BAR_MUL_BIP = 5'h09;
    localparam logic [4:0] BAR_MUL_LZ = 5'h17;
    localparam logic [4:0] BAR_MUL_RTD = 5'h08;
    localparam logic [4:0] BAR_MUL_TC = 5'h09;
    localparam logic [4:0] BAR_SH_BIP = 5'h10;
    localparam logic [4:0] BAR_SH_LZ = 5'h10;
    localparam logic [4:0] BAR_SH_RTD = 5'h0d;
    localparam logic [4:0] BAR_SH_TC = 5'h0f;
    localparam logic [3:0] BAR_FULL = 4'h8;  // Number of bar LEDs

    // ****************************************
    // Test sequence states
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SEL = 6'h02,
        ST_SHOW = 6'h04,
        ST_NEXT = 6'h08,
        ST_LAMP = 6'h10,
        ST_ADDR = 6'h20
    } amdd_state_e;
endpackage
`default_nettype wire

// ---- verilog/amdd_bar.sv ----
`timescale 1ns/1ps
`default_nettype none
module amdd_bar
    import amdd_pkg::*;
(
    // Selected analog word and its range
    input wire logic [15:0] value,
    input wire logic [1:0] rangeSel,
    // Thermometer code for eight LEDs
    output logic [7:0] bar
);
    // ****************************************
    // Scaling to a count of lit LEDs
    // ****************************************
    logic signed [17:0] offset;  // Range offset
    logic signed [17:0] shifted; // Word moved so that minimum is zero
    logic [16:0] span;           // Clipped at zero below minimum
    logic [4:0] mul;
    logic [4:0] sh;
    logic [21:0] prod;
    logic [21:0] level;
    logic [3:0] lit;

    // Constant multiply avoids a divider; rounding is coarse by design
    always_comb begin
        case (rangeSel)
            RNG_LIVEZ: begin
                offset = BAR_OFF_LZ;
                mul = BAR_MUL_LZ;
                sh = BAR_SH_LZ;
            end
            RNG_RTD: begin
                offset = BAR_OFF_RTD;
                mul = BAR_MUL_RTD;
                sh = BAR_SH_RTD;
            end
            RNG_TC: begin
                offset = BAR_OFF_TC;
                mul = BAR_MUL_TC;
                sh = BAR_SH_TC;
            end
            default: begin
                offset = BAR_OFF_BIP;
                mul = BAR_MUL_BIP;
                sh = BAR_SH_BIP;
            end
        endcase
        shifted = 18'(signed'({{2{value[15]}}, value})) + offset;
        // Below minimum shows no LED
        span = shifted[17] ? 17'h00000 : shifted[16:0];
        prod = 22'(span * mul);
        level = prod >> sh;
        // Above maximum shows every LED
        lit = (level > 22'(BAR_FULL)) ? BAR_FULL : level[3:0];
        bar = 8'((9'h001 << lit) - 9'h001);
    end
endmodule // amdd_bar
`default_nettype wire

// ---- verilog/amdd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Switch eight moves words to offsets 8-15
// - Eight input words, one per channel
// - All LEDs lit during self-initialisation
// - Bus LED flashes when bus stopped
// - Any error lights error LED; open and overflow send message
// - Detect open wire, internal and bus faults
// - Store error type and channel until read
// - Open circuit reports class four, number 09
// - Overflow reports class four, number 10
// - First press selects channel 0, flashes LED
// - Release shows channel flags three seconds
// - LED 0 unit, 1 bus, 3 open, 4 overflow
// - Further presses advance to next channel
// - Press after last channel runs lamp test
// - Then show address switches five seconds
// - Clear errors only when gone and acknowledged
// - Ack by long hold, PC or program
// - Idle button shows selected value as bar
// - Bar scale follows configured range
module amdd_top
    import amdd_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC  // Cycles per millisecond tick
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Input word reads by the bus master
    input wire logic inputWordRd,
    input wire logic [3:0] inputWordAddr,
    output logic inputWordHit,
    output logic [15:0] inputWordData,
    // Converted channel values and configuration
    input wire logic [7:0][15:0] chanValue,
    input wire logic [7:0][1:0] chanRange,
    input wire logic [7:0] addrSwitch,
    // Fault sources
    input wire logic [7:0] openCircuitIn,
    input wire logic [7:0] overflowIn,
    input wire logic unitErrIn,
    input wire logic busErrIn,
    // Module status
    input wire logic initDone,
    input wire logic initFail,
    input wire logic busRunning,
    // Operator and acknowledge sources
    input wire logic testBtn,
    input wire logic pcAck,
    input wire logic plcAck,
    // Error message to the central unit
    output logic errMsgValid,
    input wire logic errMsgReady,
    output logic [3:0] errClass,
    output logic [7:0] errNumber,
    output logic [7:0] errDevType,
    output logic [7:0] errGroup,
    output logic [2:0] errChannel,
    output logic errActive,
    // Front panel LEDs
    output logic [7:0] led,
    output logic errLed,
    output logic busLed
);
    // ****************************************
    // Helpers
    // ****************************************
    // Lowest set bit of a channel vector
    function automatic logic [2:0] firstSet(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Open wire is meaningful only for temperature sensors
    function automatic logic isTemp(input logic [1:0] r);
        return (r == RNG_RTD) || (r == RNG_TC);
    endfunction

    // ****************************************
    // Millisecond tick and flash divider
    // ****************************************
    logic [15:0] divCnt_q, divCnt_d;
    logic tick;                        // One-cycle pulse per millisecond
    logic [12:0] flashCnt_q, flashCnt_d;
    logic flash_q, flash_d;            // Flashing phase

    assign tick = (divCnt_q == 16'(TICK_CYCLES - 1));

    // Next values of the dividers
    always_comb begin
        divCnt_d = tick ? 16'h0000 : divCnt_q + 16'h0001;
        flashCnt_d = flashCnt_q;
        flash_d = flash_q;
        if (tick) begin
            if (flashCnt_q == FLASH_MS - 13'h0001) begin
                flashCnt_d = 13'h0000;
                flash_d = ~flash_q;
            end else begin
                flashCnt_d = flashCnt_q + 13'h0001;
            end
        end
    end

    // Divider registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_q <= 16'h0000;
            flashCnt_q <= 13'h0000;
            flash_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_d;
            flashCnt_q <= flashCnt_d;
            flash_q <= flash_d;
        end
    end

    // ****************************************
    // Input word window
    // ****************************************
    logic hit_q, hit_d;
    logic [15:0] rdData_q, rdData_d;
    logic [3:0] winBase;

    assign winBase = addrSwitch[WINDOW_SW] ? WIN_HI : WIN_LO;

    // Only offsets inside the selected window answer
    always_comb begin
        hit_d = 1'b0;
        rdData_d = rdData_q;
        if (inputWordRd && (inputWordAddr[3] == winBase[3])) begin
            hit_d = 1'b1;
            rdData_d = chanValue[inputWordAddr[2:0]];
        end
    end

    // Read data registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hit_q <= 1'b0;
            rdData_q <= 16'h0000;
        end else begin
            hit_q <= hit_d;
            rdData_q <= rdData_d;
        end
    end

    assign inputWordHit = hit_q;
    assign inputWordData = rdData_q;

    // ****************************************
    // Test button and acknowledge
    // ****************************************
    logic btnPrev_q;
    logic [12:0] holdCnt_q, holdCnt_d;
    logic holdFired_q, holdFired_d;  // Long hold already acknowledged
    logic press, letGo, ackBtn, ack;

    assign press = testBtn & ~btnPrev_q;
    assign letGo = ~testBtn & btnPrev_q;
    assign ackBtn = tick & testBtn & ~holdFired_q &
        (holdCnt_q == HOLD_MS - 13'h0001);
    assign ack = ackBtn | pcAck | plcAck;

    // Hold time counted only while pressed
    always_comb begin
        holdCnt_d = holdCnt_q;
        holdFired_d = holdFired_q;
        if (!testBtn) begin
            holdCnt_d = 13'h0000;
            holdFired_d = 1'b0;
        end else if (tick && !holdFired_q) begin
            holdCnt_d = holdCnt_q + 13'h0001;
            if (ackBtn) begin
                holdFired_d = 1'b1;
            end
        end
    end

    // Button registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            btnPrev_q <= 1'b0;
            holdCnt_q <= 13'h0000;
            holdFired_q <= 1'b0;
        end else begin
            btnPrev_q <= testBtn;
            holdCnt_q <= holdCnt_d;
            holdFired_q <= holdFired_d;
        end
    end

    // ****************************************
    // Error storage
    // ****************************************
    logic [7:0] openCause, ovfCause;
    logic [7:0] openSt_q, openSt_d, ovfSt_q, ovfSt_d;
    logic unitSt_q, unitSt_d, busSt_q, busSt_d, failSt_q, failSt_d;

    // Qualify open wire per channel by its range
    for (genvar g = 0; g < NCH; g++) begin : gQual
        assign openCause[g] = openCircuitIn[g] & isTemp(chanRange[g]);
        assign ovfCause[g] = overflowIn[g];
    end

    // A live cause holds the flag; ack only clears a gone error
    always_comb begin
        openSt_d = openCause | (openSt_q & ~{NCH{ack}});
        ovfSt_d = ovfCause | (ovfSt_q & ~{NCH{ack}});
        unitSt_d = unitErrIn | (unitSt_q & ~ack);
        busSt_d = busErrIn | (busSt_q & ~ack);
        failSt_d = (initFail & ~initDone) | failSt_q;
    end

    // Sticky error registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            openSt_q <= 8'h00;
            ovfSt_q <= 8'h00;
            unitSt_q <= 1'b0;
            busSt_q <= 1'b0;
            failSt_q <= 1'b0;
        end else begin
            openSt_q <= openSt_d;
            ovfSt_q <= ovfSt_d;
            unitSt_q <= unitSt_d;
            busSt_q <= busSt_d;
            failSt_q <= failSt_d;
        end
    end

    assign errActive = (|openSt_q) | (|ovfSt_q) | unitSt_q | busSt_q;

    // ****************************************
    // Error messages to the central unit
    // ****************************************
    logic [7:0] pendOpen_q, pendOpen_d, pendOvf_q, pendOvf_d;
    logic msgValid_q, msgValid_d;
    logic [7:0] msgNum_q, msgNum_d;
    logic [2:0] msgChan_q, msgChan_d;

    // New detections queue until the master takes them
    always_comb begin
        pendOpen_d = pendOpen_q;
        pendOvf_d = pendOvf_q;
        msgValid_d = msgValid_q;
        msgNum_d = msgNum_q;
        msgChan_d = msgChan_q;
        if (msgValid_q && errMsgReady) begin
            msgValid_d = 1'b0;
        end else if (!msgValid_q && (|pendOpen_q)) begin
            msgValid_d = 1'b1;
            msgNum_d = ERRNO_OPEN;
            msgChan_d = firstSet(pendOpen_q);
            pendOpen_d[firstSet(pendOpen_q)] = 1'b0;
        end else if (!msgValid_q && (|pendOvf_q)) begin
            msgValid_d = 1'b1;
            msgNum_d = ERRNO_OVF;
            msgChan_d = firstSet(pendOvf_q);
            pendOvf_d[firstSet(pendOvf_q)] = 1'b0;
        end
        // A new error wins over the bit being taken
        pendOpen_d = pendOpen_d | (openCause & ~openSt_q);
        pendOvf_d = pendOvf_d | (ovfCause & ~ovfSt_q);
    end

    // Message registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pendOpen_q <= 8'h00;
            pendOvf_q <= 8'h00;
            msgValid_q <= 1'b0;
            msgNum_q <= 8'h00;
            msgChan_q <= 3'h0;
        end else begin
            pendOpen_q <= pendOpen_d;
            pendOvf_q <= pendOvf_d;
            msgValid_q <= msgValid_d;
            msgNum_q <= msgNum_d;
            msgChan_q <= msgChan_d;
        end
    end

    assign errMsgValid = msgValid_q;
    assign errClass = ERR_CLASS_FOUR;
    assign errNumber = msgNum_q;
    assign errDevType = DEV_TYPE;
    assign errGroup = {1'b0, addrSwitch[6:0]};
    assign errChannel = msgChan_q;

    // ****************************************
    // Test sequence
    // ****************************************
    amdd_state_e state_q, state_d;
    logic [2:0] sel_q, sel_d;      // Channel under diagnosis
    logic [12:0] tmr_q, tmr_d;     // Display period in ticks

    // Press, release and display timeouts move the sequence
    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        tmr_d = tick ? tmr_q + 13'h0001 : tmr_q;
        case (state_q)
            ST_IDLE: begin
                if (press) begin
                    sel_d = 3'h0;
                    state_d = ST_SEL;
                end
            end
            ST_SEL: begin
                if (letGo) begin
                    tmr_d = 13'h0000;
                    // A long hold was an acknowledge only
                    state_d = holdFired_q ? ST_IDLE : ST_SHOW;
                end
            end
            ST_SHOW, ST_NEXT: begin
                if (press) begin
                    if (sel_q == 3'(NCH - 1)) begin
                        state_d = ST_LAMP;
                    end else begin
                        sel_d = sel_q + 3'h1;
                        state_d = ST_SEL;
                    end
                end else if (state_q == ST_SHOW && tick &&
                    tmr_q == SHOW_MS - 13'h0001) begin
                    state_d = ST_NEXT;
                end
            end
            ST_LAMP: begin
                if (letGo) begin
                    tmr_d = 13'h0000;
                    state_d = holdFired_q ? ST_IDLE : ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (tick && tmr_q == ADDR_MS - 13'h0001) begin
                    sel_d = 3'h0;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequence registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            sel_q <= 3'h0;
            tmr_q <= 13'h0000;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            tmr_q <= tmr_d;
        end
    end

    // ****************************************
    // LED drive
    // ****************************************
    logic [7:0] bar;
    logic [7:0] led_q, led_d;
    logic errLed_q, errLed_d, busLed_q, busLed_d;

    // Bar of the channel currently selected
    amdd_bar uBar (
        .value(chanValue[sel_q]),
        .rangeSel(chanRange[sel_q]),
        .bar(bar)
    );

    // Init and lamp test override every other display
    always_comb begin
        led_d = bar;
        errLed_d = failSt_q | errActive;
        busLed_d = busRunning ? 1'b1 : flash_q;
        if (!initDone) begin
            led_d = 8'hff;
            errLed_d = 1'b1;
            busLed_d = 1'b1;
        end else begin
            case (state_q)
                ST_SEL: begin
                    led_d = flash_q ? 8'(8'h01 << sel_q) : 8'h00;
                end
                ST_SHOW: begin
                    led_d = 8'h00;
                    led_d[DIAG_UNIT] = unitSt_q;
                    led_d[DIAG_BUS] = busSt_q;
                    led_d[DIAG_OPEN] = openSt_q[sel_q];
                    led_d[DIAG_OVF] = ovfSt_q[sel_q];
                end
                ST_LAMP: begin
                    led_d = 8'hff;
                    errLed_d = 1'b1;
                    busLed_d = 1'b1;
                end
                ST_ADDR: begin
                    led_d = addrSwitch;
                end
                default: begin
                    led_d = bar;
                end
            endcase
        end
    end

    // LED registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_q <= 8'hff;
            errLed_q <= 1'b1;
            busLed_q <= 1'b1;
        end else begin
            led_q <= led_d;
            errLed_q <= errLed_d;
            busLed_q <= busLed_d;
        end
    end

    assign led = led_q;
    assign errLed = errLed_q;
    assign busLed = busLed_q;
endmodule // amdd_top
`default_nettype wire

// ---- tb/amdd_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module amdd_sva
    import amdd_pkg::*;
(
    // Clock, reset and status
    input wire logic clk, sys_rst, initDone, busRunning,
    // Input word reads
    input wire logic inputWordRd, inputWordHit,
    input wire logic [3:0] inputWordAddr,
    input wire logic [15:0] inputWordData,
    input wire logic [7:0][15:0] chanValue,
    input wire logic [7:0] addrSwitch, led,
    // Error message and LEDs
    input wire logic errMsgValid, errMsgReady, errActive, errLed, busLed,
    input wire logic [3:0] errClass,
    input wire logic [7:0] errNumber, errGroup,
    input wire logic [2:0] errChannel
);
    logic [15:0] expWord_q;  // Word a read should return next cycle
    wire logic readTaken = inputWordRd && inputWordAddr[3] == addrSwitch[7];
    // Remember the addressed word; data may change after the read
    always_ff @(posedge clk) begin
        expWord_q <= chanValue[inputWordAddr[2:0]];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_read_hit: assert property (readTaken |=> inputWordHit)
        else $error("read in window not answered");
    a_read_miss: assert property (!readTaken |=> !inputWordHit)
        else $error("read outside window answered");
    a_read_data: assert property (readTaken |=>
        inputWordData == expWord_q) else $error("read data wrong");
    a_init_lit: assert property (!$past(initDone)
        && !$past(initDone, 2) |-> led == 8'hff && errLed)
        else $error("LEDs dark in init");
    a_bus_steady: assert property ($past(busRunning)
        && $past(initDone) && $past(busRunning, 2) |-> busLed)
        else $error("bus LED off");
    a_msg_hold: assert property (errMsgValid && !errMsgReady |=>
        errMsgValid && $stable(errNumber) && $stable(errChannel))
        else $error("message dropped before accept");
    a_msg_fields: assert property (errMsgValid |->
        errClass == ERR_CLASS_FOUR
        && errGroup == {1'b0, addrSwitch[6:0]}
        && (errNumber == ERRNO_OPEN || errNumber == ERRNO_OVF))
        else $error("message fields wrong");
    a_msg_cause: assert property ($rose(errMsgValid) |-> errActive)
        else $error("message without error");
    a_err_led: assert property ($past(errActive)
        && $past(errActive, 2) |-> errLed) else $error("error LED off");
    cover property (inputWordHit);
    cover property (errMsgValid && errMsgReady);
    cover property (led == 8'hff && initDone);
endmodule // amdd_sva
bind amdd_top amdd_sva amdd_sva_i (.clk, .sys_rst, .initDone, .busRunning,
    .inputWordRd, .inputWordHit, .inputWordAddr, .inputWordData, .chanValue,
    .addrSwitch, .led, .errMsgValid, .errMsgReady, .errActive, .errLed,
    .busLed, .errClass, .errNumber, .errGroup, .errChannel);
`default_nettype wire

// ---- tb/amdd_central.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Central unit model
// ****
module amdd_central (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Message handshake
    input wire logic errMsgValid,
    output logic errMsgReady,
    // Bench controls: slow acceptance, program acknowledge
    input wire logic slow,
    input wire logic ackReq,
    output logic plcAck
);
    logic [1:0] pace_q;  // Slow mode takes one message in four cycles
    // Accept messages; program ack is a single pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pace_q <= 2'h0;
            errMsgReady <= 1'b0;
            plcAck <= 1'b0;
        end else begin
            pace_q <= pace_q + 2'h1;
            errMsgReady <= errMsgValid && (!slow || pace_q == 2'h2);
            plcAck <= ackReq && !plcAck;
        end
    end
endmodule // amdd_central
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import amdd_pkg::*;
    localparam int TK = 4;  // Short tick keeps long displays brief
    logic clk, sys_rst, inputWordRd, inputWordHit, errMsgValid, errMsgReady;
    logic [3:0] inputWordAddr, errClass;
    logic [15:0] inputWordData;
    logic [7:0][15:0] chanValue;
    logic [7:0][1:0] chanRange;
    logic [7:0] addrSwitch, openCircuitIn, overflowIn, errNumber, led;
    logic [7:0] errDevType, errGroup;
    logic unitErrIn, busErrIn, initDone, initFail, busRunning, testBtn;
    logic pcAck, plcAck, ackReq, slow, errActive, errLed, busLed;
    logic flashPhase;  // Bus LED level one flash phase earlier
    logic [2:0] errChannel;
    logic [15:0] rdQ[$];  // Expected read words
    logic [14:0] msgQ[$];  // Expected class, number, channel
    int mismatches, tests_run, seed;
    amdd_top #(.TICK_CYCLES(TK)) amdd_top_i (.*);
    amdd_central amdd_central_i (.clk, .sys_rst, .errMsgValid, .errMsgReady,
        .slow, .ackReq, .plcAck);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Button edge, then let state and LEDs settle
    task automatic btn(input logic v);
        testBtn = v;
        cyc(4);
    endtask
    // Watcher: an empty queue gives x, so a stray result mismatches
    always @(negedge clk) begin
        if (inputWordHit === 1'b1) begin
            chk(inputWordData, rdQ.size() ? rdQ.pop_front() : 'x);
        end
        if (errMsgValid === 1'b1 && errMsgReady === 1'b1) begin
            chk({errClass, errNumber, errChannel},
                msgQ.size() ? msgQ.pop_front() : 'x);
            chk(errDevType, DEV_TYPE);
        end
    end
    initial begin
        #4_000_000;
        mismatches++;
        complete_run();
    end
    initial begin
        seed = 30;
        {mismatches, tests_run} = '0;
        {inputWordRd, inputWordAddr, openCircuitIn, overflowIn} = '0;
        {unitErrIn, busErrIn, initDone, initFail, testBtn, pcAck} = '0;
        {ackReq, slow, chanRange} = '0;
        busRunning = 1'b1;
        addrSwitch = 8'h25;
        chanRange[2] = RNG_RTD;
        for (int i = 0; i < 8; i++) chanValue[i] = 16'($random(seed));
        chanValue[0] = 16'h8000;
        sys_rst = 1'b1;
        cyc(8);
        sys_rst = 1'b0;
        cyc(3);
        chk(led, 8'hff);
        initDone = 1'b1;
        cyc(4);
        chk(led, 8'h00);
        // All offsets back to back, window low then high
        repeat (2) begin
            for (int a = 0; a < 16; a++) begin
                inputWordRd = 1'b1;
                inputWordAddr = 4'(a);
                if (a / 8 == addrSwitch[7]) begin
                    rdQ.push_back(chanValue[a % 8]);
                end
                cyc(1);
            end
            inputWordRd = 1'b0;
            addrSwitch = 8'ha5;
            cyc(2);
            // Every read in the window must have been answered
            chk(rdQ.size(), 0);
        end
        // Faults with a slow receiver; ch0 open is ignored as bipolar
        slow = 1'b1;
        {openCircuitIn, overflowIn} = {8'h05, 8'h09};
        {unitErrIn, busErrIn} = 2'h3;
        msgQ.push_back({ERR_CLASS_FOUR, ERRNO_OPEN, 3'h2});
        msgQ.push_back({ERR_CLASS_FOUR, ERRNO_OVF, 3'h0});
        msgQ.push_back({ERR_CLASS_FOUR, ERRNO_OVF, 3'h3});
        cyc(30);
        chk(msgQ.size(), 0);
        pcAck = 1'b1;
        cyc(1);
        pcAck = 1'b0;
        cyc(2);
        chk(errActive, 1);
        // Step through every channel's error display
        for (int c = 0; c < 8; c++) begin
            btn(1'b1);
            chk(led & ~(8'h01 << c), 8'h00);
            btn(1'b0);
            chk(led, {3'h0, overflowIn[c], c == 2, 3'h3});
        end
        btn(1'b1);
        chk({led, errLed, busLed}, 10'h3ff);
        btn(1'b0);
        chk(led, addrSwitch);
        cyc(5000 * TK + 20);
        btn(1'b1);
        btn(1'b0);
        chk(led, 8'h13);
        {openCircuitIn, overflowIn, unitErrIn, busErrIn} = '0;
        cyc(2);
        chk(errActive, 1);
        ackReq = 1'b1;
        cyc(1);
        ackReq = 1'b0;
        cyc(3);
        chk(errActive, 0);
        chanValue[0] = 16'h7fff;
        cyc(3000 * TK + 20);
        chk({led, errLed}, 9'h1fe);
        // Long hold acknowledges a unit fault that has gone
        unitErrIn = 1'b1;
        cyc(2);
        unitErrIn = 1'b0;
        btn(1'b1);
        chk(errActive, 1);
        cyc(5000 * TK + 8);
        chk(errActive, 0);
        btn(1'b0);
        // Stopped bus: LED level flips every flash half period
        busRunning = 1'b0;
        cyc(2);
        flashPhase = busLed;
        cyc(250 * TK);
        chk(busLed, !flashPhase);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
